// ===== src/swdt_pkg.sv
// Shared constants and types of the system watchdog timer.
// Assumes a 125 MHz core clock and a 32-bit APB register bus.
package swdt_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_US = 10240;
  localparam int TICK_CYCLES =
    (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int PRE_W = 21;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [31:0] WDT_BASE = 32'h5000_3100;
  localparam logic [31:0] COUNT_IDX = 32'h5000_3100;
  localparam logic [31:0] CTRL_IDX = 32'h5000_3102;
  localparam logic [11:0] COUNT_ADDR = 12'((COUNT_IDX - WDT_BASE) * 4);
  localparam logic [11:0] CTRL_ADDR = 12'((CTRL_IDX - WDT_BASE) * 4);
  localparam logic [11:0] STAT_ADDR = 12'h010;
  localparam logic [11:0] MASK_ADDR = 12'h014;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int KEY_LSB = 9;
  localparam int KEY_W = 7;
  localparam int VAL_W = 8;
  localparam int CNT_W = 9;
  localparam int SIGN_BIT = 8;
  localparam int RST_ONLY_BIT = 0;
  localparam int SPARE_BIT = 1;
  localparam int EV_NMI = 0;
  localparam int EV_RST = 1;
  localparam int EV_W = 2;
  localparam logic [8:0] COUNT_RESET = 9'h0FF;
  localparam logic [8:0] COUNT_RELOAD = 9'h0FF;
  localparam logic [8:0] COUNT_LIMIT = 9'h1F0;
  localparam logic [8:0] COUNT_ZERO = 9'h000;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] EV_RESET = 2'h0;

  // ---------------------------------------------------------------
  // APB carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } swdt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } swdt_apb_rsp_t;

endpackage

// ===== src/swdt_top.sv
// System watchdog timer: 9-bit signed down counter with key-filtered
// reload, NMI / system reset generation and an APB register slave.
// Assumes APB master on core_clk; freeze and debug halt inputs are
// synchronous to core_clk.
//
// How it works
// - A count write is taken only when the key field bits 15:9 are zero.
// - A taken write loads bits 7:0 as the new positive count.
// - The running count drops by one every 10.24 ms.
// - Reads give the live 9-bit count, bit 8 the sign, 0 then 1FF then 1FE.
// - In NMI mode reaching zero raises the NMI and counting goes on.
// - In NMI mode the count 1F0 issues a system reset and reloads FF.
// - In reset-only mode a count at or below zero resets and reloads FF.
// - In NMI mode the external freeze bit stops and resumes counting.
// - In reset-only mode the freeze bit is ignored.
// - Software can set the reset-only bit but never clear it.
// - A debug halt of the core always freezes the count.
//
// Design decision made here: register access over APB.
module swdt_top
  import swdt_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire swdt_apb_req_t apbReq,
  output swdt_apb_rsp_t apbRsp,
  input wire logic freezeControlBit,
  input wire logic debugHalt,
  output logic nmiReq,
  output logic sysResetReq,
  output logic irq
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic setupPhase;
  logic accessDone;
  logic [11:0] addrLow;
  logic hitCount;
  logic hitCtrl;
  logic hitStat;
  logic hitMask;
  logic mapped;
  logic wrCount;
  logic wrCtrl;
  logic wrMask;
  logic rdStat;
  logic keyOk;

  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign accessDone = apbReq.psel && apbReq.penable;
  assign addrLow = apbReq.paddr[11:0];
  assign hitCount = addrLow == COUNT_ADDR;
  assign hitCtrl = addrLow == CTRL_ADDR;
  assign hitStat = addrLow == STAT_ADDR;
  assign hitMask = addrLow == MASK_ADDR;
  assign mapped = hitCount || hitCtrl || hitStat || hitMask;
  assign wrCount = accessDone && apbReq.pwrite && hitCount;
  assign wrCtrl = accessDone && apbReq.pwrite && hitCtrl;
  assign wrMask = accessDone && apbReq.pwrite && hitMask;
  assign rdStat = accessDone && !apbReq.pwrite && hitStat;
  assign keyOk = apbReq.pwdata[KEY_LSB +: KEY_W] == 7'h00;

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  logic [PRE_W-1:0] pre;
  logic [PRE_W-1:0] next_pre;
  logic tick;

  assign tick = pre == PRE_W'(TICK_LEN - 1);

  always_comb begin
    next_pre = tick ? '0 : PRE_W'(pre + 1'b1);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pre <= '0;
    end else begin
      pre <= next_pre;
    end
  end

  // ---------------------------------------------------------------
  // Watchdog core
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic rstOnly;
  logic next_rstOnly;
  logic spare;
  logic next_spare;
  logic next_nmiReq;
  logic next_sysResetReq;
  logic atOrBelowZero;
  logic fire;
  logic frozen;

  assign atOrBelowZero = (count == COUNT_ZERO) || count[SIGN_BIT];
  assign fire = rstOnly ? atOrBelowZero : (count == COUNT_LIMIT);
  assign frozen = debugHalt || (freezeControlBit && !rstOnly);

  always_comb begin
    next_count = count;
    next_rstOnly = rstOnly;
    next_spare = spare;
    if (wrCtrl) begin
      next_rstOnly = rstOnly | apbReq.pwdata[RST_ONLY_BIT];
      next_spare = apbReq.pwdata[SPARE_BIT];
    end
    if (fire) begin
      next_count = COUNT_RELOAD;
      next_rstOnly = 1'b0;
    end else if (wrCount && keyOk) begin
      next_count = {1'b0, apbReq.pwdata[VAL_W-1:0]};
    end else if (tick && !frozen) begin
      next_count = CNT_W'(count - 1'b1);
    end
    next_sysResetReq = fire;
    next_nmiReq = !rstOnly && !fire && (next_count == COUNT_ZERO)
      && (count != COUNT_ZERO);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= COUNT_RESET;
      rstOnly <= CTRL_RESET[RST_ONLY_BIT];
      spare <= CTRL_RESET[SPARE_BIT];
      nmiReq <= 1'b0;
      sysResetReq <= 1'b0;
    end else begin
      count <= next_count;
      rstOnly <= next_rstOnly;
      spare <= next_spare;
      nmiReq <= next_nmiReq;
      sysResetReq <= next_sysResetReq;
    end
  end

  // ---------------------------------------------------------------
  // Event status, mask and read data
  // ---------------------------------------------------------------
  logic [EV_W-1:0] evStat;
  logic [EV_W-1:0] next_evStat;
  logic [EV_W-1:0] evMask;
  logic [EV_W-1:0] next_evMask;
  logic [31:0] rdData;
  logic [31:0] next_rdData;
  logic [EV_W-1:0] evSet;

  assign evSet = {next_sysResetReq, next_nmiReq};

  always_comb begin
    next_rdData = rdData;
    if (setupPhase) begin
      next_rdData = 32'h0000_0000;
      if (hitCount) begin
        next_rdData[CNT_W-1:0] = count;
      end else if (hitCtrl) begin
        next_rdData[SPARE_BIT] = spare;
        next_rdData[RST_ONLY_BIT] = rstOnly;
      end else if (hitStat) begin
        next_rdData[EV_W-1:0] = evStat;
      end else if (hitMask) begin
        next_rdData[EV_W-1:0] = evMask;
      end
    end
    // Only the bits shown to software are cleared; new events win
    next_evStat = evStat;
    if (rdStat) begin
      next_evStat = evStat & ~rdData[EV_W-1:0];
    end
    next_evStat = next_evStat | evSet;
    next_evMask = wrMask ? apbReq.pwdata[EV_W-1:0] : evMask;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      evStat <= EV_RESET;
      evMask <= EV_RESET;
      rdData <= 32'h0000_0000;
    end else begin
      evStat <= next_evStat;
      evMask <= next_evMask;
      rdData <= next_rdData;
    end
  end

  assign irq = |(evStat & evMask);
  // One driver for the whole response carrier
  assign apbRsp = '{
    prdata: rdData,
    pready: 1'b1,
    pslverr: accessDone && !mapped
  };

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_enter_zero;
    !rstOnly && count != COUNT_ZERO ##1 count == COUNT_ZERO;
  endsequence

  sequence s_reload_fire;
    sysResetReq && count == COUNT_RELOAD;
  endsequence

  a_key_blocks_load: assert property (
    wrCount && !keyOk && !fire && !(tick && !frozen) |=> $stable(count))
    else $error("count changed on a write with nonzero key");

  a_key_loads_value: assert property (
    wrCount && keyOk && !fire
    |=> count == {1'b0, $past(apbReq.pwdata[7:0])})
    else $error("accepted write did not load low byte");

  a_tick_decrements: assert property (
    tick && !frozen && !fire && !wrCount
    |=> count == CNT_W'($past(count) - 1'b1))
    else $error("count did not step down on tick");

  a_read_live_count: assert property (
    setupPhase && hitCount |=> rdData == {23'h0, $past(count)})
    else $error("count read data wrong");

  a_nmi_on_zero: assert property (
    s_enter_zero |-> nmiReq)
    else $error("no NMI on entry into zero");

  a_reset_at_limit: assert property (
    !rstOnly && count == COUNT_LIMIT |=> s_reload_fire)
    else $error("no reset and reload at 1F0");

  a_reset_only_fire: assert property (
    rstOnly && atOrBelowZero |=> s_reload_fire and !nmiReq)
    else $error("reset-only mode missed reset or raised NMI");

  a_soft_freeze: assert property (
    freezeControlBit && !rstOnly && !wrCount && !fire |=> $stable(count))
    else $error("count moved while frozen");

  a_no_soft_freeze: assert property (
    rstOnly && freezeControlBit && !debugHalt && tick && !fire && !wrCount
    |=> count == CNT_W'($past(count) - 1'b1))
    else $error("reset-only mode obeyed freeze");

  a_select_sticky: assert property (
    rstOnly && !fire |=> rstOnly)
    else $error("reset-only bit cleared by software");

  a_debug_freeze: assert property (
    debugHalt && !wrCount && !fire |=> $stable(count))
    else $error("count moved during debug halt");

  a_nmi_once: assert property (
    nmiReq |=> !nmiReq)
    else $error("NMI retriggered");

  a_nmi_not_negative: assert property (
    count[SIGN_BIT] |-> !nmiReq)
    else $error("NMI while count negative");

  a_nmi_sets_status: assert property (
    nmiReq |-> evStat[EV_NMI])
    else $error("NMI event not recorded");

  a_rst_sets_status: assert property (
    sysResetReq |-> evStat[EV_RST])
    else $error("reset event not recorded");

  a_irq_on_nmi: assert property (
    nmiReq && evMask[EV_NMI] |-> irq)
    else $error("unmasked NMI event gave no interrupt");

  a_stat_read_clear: assert property (
    rdStat && rdData[EV_NMI] && !next_nmiReq |=> !evStat[EV_NMI])
    else $error("status read did not clear NMI event");

  a_rst_pulse: assert property (
    sysResetReq |=> !sysResetReq)
    else $error("system reset request longer than one cycle");

  a_no_early_reset: assert property (
    !rstOnly && count != COUNT_LIMIT |=> !sysResetReq)
    else $error("NMI mode reset away from 1F0");

  a_reset_only_no_nmi: assert property (
    rstOnly |=> !nmiReq)
    else $error("NMI raised in reset-only mode");

  a_select_set: assert property (
    wrCtrl && apbReq.pwdata[RST_ONLY_BIT] && !fire |=> rstOnly)
    else $error("reset-only bit could not be set");

  a_select_clear_fire: assert property (
    rstOnly && fire |=> !rstOnly)
    else $error("reset-only bit kept over watchdog reset");

  a_select_no_rise: assert property (
    !rstOnly && !(wrCtrl && apbReq.pwdata[RST_ONLY_BIT])
    |=> !rstOnly)
    else $error("reset-only bit rose without a write");

  a_count_hold_idle: assert property (
    !tick && !wrCount && !fire |=> $stable(count))
    else $error("count moved between ticks");

  a_load_positive: assert property (
    wrCount && keyOk && !fire |=> !count[SIGN_BIT])
    else $error("loaded count is negative");

  a_wrap_below_zero: assert property (
    tick && !frozen && count == COUNT_ZERO && !fire && !wrCount
    |=> count == 9'h1FF)
    else $error("count did not wrap from 0 to 1FF");

  a_nmi_at_zero: assert property (
    nmiReq |-> count == COUNT_ZERO)
    else $error("NMI away from count zero");

  a_pre_restart: assert property (
    tick |=> pre == '0)
    else $error("prescaler did not restart on tick");

  a_pre_counts: assert property (
    !tick |=> pre == PRE_W'($past(pre) + 1'b1))
    else $error("prescaler did not count");

  a_read_ctrl: assert property (
    setupPhase && hitCtrl |=> rdData == {30'h0, $past(spare), $past(rstOnly)})
    else $error("control read data wrong");

  sequence s_unfrozen_tick;
    !rstOnly && !freezeControlBit && !debugHalt && tick && !fire && !wrCount;
  endsequence

  a_freeze_resume: assert property (
    s_unfrozen_tick |=> count == CNT_W'($past(count) - 1'b1))
    else $error("count did not resume after freeze");

endmodule

// ===== verif/test_system_watchdog_timer.sv
// Self-checking bench of the system watchdog timer.
// Assumes swdt_top with a shortened tick and its APB slave at 0 waits.
module test_system_watchdog_timer
  import swdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic coreClk;
  logic rst;
  swdt_apb_req_t apbReq;
  swdt_apb_rsp_t apbRsp;
  logic freezeControlBit;
  logic debugHalt;
  logic nmiReq;
  logic sysResetReq;
  logic irq;
  int numErrors = 0;
  int samplesChecked = 0;
  int nmiCount = 0;
  int rstCount = 0;
  logic [32:0] expQ[$];
  logic [6:0] key;
  logic [7:0] val;

  swdt_top #(.TICK_LEN(8)) dut (
    .core_clk(coreClk),
    .rst(rst),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .freezeControlBit(freezeControlBit),
    .debugHalt(debugHalt),
    .nmiReq(nmiReq),
    .sysResetReq(sysResetReq),
    .irq(irq)
  );

  initial begin
    coreClk = 1'b0;
    forever #4 coreClk = ~coreClk;
  end

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic compare(input logic [32:0] seen, input logic [32:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Read results are taken off the queue as they appear on the bus
  always @(posedge coreClk) begin
    if (apbReq.psel && apbReq.penable && !apbReq.pwrite &&
        apbRsp.pready === 1'b1) begin
      compare({apbRsp.pslverr, apbRsp.prdata}, expQ.pop_front());
    end
    if (nmiReq === 1'b1) nmiCount++;
    if (sysResetReq === 1'b1) rstCount++;
  end

  initial begin
    repeat (5000) @(posedge coreClk);
    numErrors++;
    conclude();
  end

  // ---------------------------------------------------------------
  // Bus and event tasks
  // ---------------------------------------------------------------
  task automatic apbXfer(input logic wr, input logic [11:0] addr,
                         input logic [31:0] data);
    @(posedge coreClk);
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= wr;
    apbReq.paddr <= {20'h0, addr};
    apbReq.pwdata <= data;
    @(posedge coreClk);
    apbReq.penable <= 1'b1;
    @(posedge coreClk);
    while (apbRsp.pready !== 1'b1) @(posedge coreClk);
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic apbRead(input logic [11:0] addr, input logic [32:0] exp);
    expQ.push_back(exp);
    apbXfer(1'b0, addr, 32'h0);
  endtask

  task automatic waitPulse(input logic isNmi);
    int n;
    n = 0;
    do begin
      @(posedge coreClk);
      #1;
      n++;
    end while ((isNmi ? nmiReq : sysResetReq) !== 1'b1 && n < 400);
    if (n >= 400) compare(33'h1, 33'h0);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hBFA3));
    apbReq = '0;
    freezeControlBit = 1'b0;
    debugHalt = 1'b1;
    rst = 1'b1;
    repeat (6) @(posedge coreClk);
    rst <= 1'b0;
    key = 7'($urandom_range(127, 1));
    val = 8'($urandom_range(255, 1));
    apbRead(COUNT_ADDR, 33'h0FF);
    apbRead(CTRL_ADDR, 33'h0);
    apbRead(STAT_ADDR, 33'h0);
    apbRead(MASK_ADDR, 33'h0);
    apbRead(12'h004, 33'h1_0000_0000);
    apbXfer(1'b1, COUNT_ADDR, {16'h0, key, 1'b0, 8'h12});
    apbRead(COUNT_ADDR, 33'h0FF);
    apbXfer(1'b1, COUNT_ADDR, {24'h0, val});
    apbRead(COUNT_ADDR, {25'h0, val});
    apbXfer(1'b1, MASK_ADDR, 32'h3);
    apbXfer(1'b1, COUNT_ADDR, 32'h2);
    @(posedge coreClk);
    debugHalt <= 1'b0;
    waitPulse(1'b1);
    compare({32'h0, irq}, 33'h1);
    repeat (10) @(posedge coreClk);
    apbRead(COUNT_ADDR, 33'h1FF);
    repeat (6) @(posedge coreClk);
    apbRead(COUNT_ADDR, 33'h1FE);
    waitPulse(1'b0);
    @(posedge coreClk);
    debugHalt <= 1'b1;
    apbRead(COUNT_ADDR, 33'h0FF);
    compare(33'(nmiCount), 33'h1);
    apbRead(STAT_ADDR, 33'h3);
    repeat (2) @(posedge coreClk);
    #1;
    compare({32'h0, irq}, 33'h0);
    @(posedge coreClk);
    debugHalt <= 1'b0;
    freezeControlBit <= 1'b1;
    apbXfer(1'b1, COUNT_ADDR, 32'h40);
    repeat (40) @(posedge coreClk);
    apbRead(COUNT_ADDR, 33'h040);
    apbXfer(1'b1, COUNT_ADDR, 32'h1);
    @(posedge coreClk);
    freezeControlBit <= 1'b0;
    waitPulse(1'b1);
    apbRead(STAT_ADDR, 33'h1);
    @(posedge coreClk);
    debugHalt <= 1'b1;
    freezeControlBit <= 1'b1;
    apbXfer(1'b1, MASK_ADDR, 32'h0);
    apbXfer(1'b1, COUNT_ADDR, 32'h3);
    apbXfer(1'b1, CTRL_ADDR, 32'h3);
    apbXfer(1'b1, CTRL_ADDR, 32'h0);
    apbRead(CTRL_ADDR, 33'h1);
    repeat (30) @(posedge coreClk);
    apbRead(COUNT_ADDR, 33'h003);
    @(posedge coreClk);
    debugHalt <= 1'b0;
    waitPulse(1'b0);
    compare(33'(nmiCount), 33'h2);
    compare({32'h0, irq}, 33'h0);
    apbRead(CTRL_ADDR, 33'h0);
    apbRead(STAT_ADDR, 33'h2);
    compare(33'(rstCount), 33'h2);
    repeat (2) @(posedge coreClk);
    conclude();
  end
endmodule
